//--- lar_pkg.sv
// Purpose: constants and types for the line autoreclose sequencer
// Assumes: 250 MHz system clock, 10 ms timer tick
// Notes: timer settings are counts of 10 ms ticks
package lar_pkg;
  localparam int unsigned LAR_CLK_HZ = 250000000;
  localparam int unsigned LAR_TICK_MS = 10;
  localparam int unsigned LAR_TICK_CYCLES = LAR_CLK_HZ / 1000 * LAR_TICK_MS;
  localparam int LAR_TIME_W = 16;
  localparam int LAR_SHOT_W = 3;
  localparam logic [LAR_SHOT_W-1:0] LAR_SHOT_MAX = 3'h4;
  localparam logic [LAR_SHOT_W-1:0] LAR_SHOT_MIN = 3'h1;
  localparam logic [LAR_SHOT_W-1:0] LAR_SHOT_DEF = 3'h2;
  // Defaults in ticks of 10 ms
  localparam logic [LAR_TIME_W-1:0] LAR_DT3_1_DEF = 16'h0032;
  localparam logic [LAR_TIME_W-1:0] LAR_DT3_2_DEF = 16'h0078;
  localparam logic [LAR_TIME_W-1:0] LAR_DT3_3_DEF = 16'h00c8;
  localparam logic [LAR_TIME_W-1:0] LAR_DT3_4_DEF = 16'h0190;
  localparam logic [LAR_TIME_W-1:0] LAR_CLOSE_DEF = 16'h000a;
  localparam logic [LAR_TIME_W-1:0] LAR_MANBLK_DEF = 16'h03e8;
  localparam logic [LAR_TIME_W-1:0] LAR_EXT_DEF = 16'h0032;
  localparam logic [LAR_TIME_W-1:0] LAR_RESET_DEF = 16'h1770;
  // Evolving-fault delay: 1.25 power cycles at nominal 60 Hz, in microseconds
  localparam int unsigned LAR_FORCE_DELAY_US = 20833;
  localparam int unsigned LAR_FORCE_CYCLES = LAR_FORCE_DELAY_US * (LAR_CLK_HZ / 1000000);
  localparam int LAR_FCNT_W = 23;
  typedef enum logic [1:0] {
    LAR_PROG_ONE_THREE,
    LAR_PROG_ONE_ONLY,
    LAR_PROG_THREE_A,
    LAR_PROG_THREE_B
  } lar_prog_t;
  typedef enum logic [1:0] {
    LAR_SEQ_BKR1,
    LAR_SEQ_BKR2,
    LAR_SEQ_BOTH,
    LAR_SEQ_ONE_TWO
  } lar_seq_t;
  typedef enum {
    LAR_ST_DISABLED,
    LAR_ST_RESET,
    LAR_ST_DEAD,
    LAR_ST_CLOSE,
    LAR_ST_TRANSFER,
    LAR_ST_CLOSE2,
    LAR_ST_RECLAIM,
    LAR_ST_LOCKOUT
  } lar_state_t;
endpackage

//--- lar_sequencer.sv
// Overview of operation
// - Four reclose programs selectable; single-or-three-pole is the default.
// - Shot limit from one to four attempts, default two.
// - Every timer setting spans 0 to 655.35 s in 10 ms steps.
// - Four three-pole dead times, defaults 0.50, 1.20, 2.00, 4.00 s.
// - Breaker one close pulse bounded by its close time, default 0.10 s.
// - Manual close blocks reclosing for a set time, default 10 s.
// - Extend input lengthens a three-pole first dead time by set extension, default 0.50 s.
// - Reset input and reset time, default 60 s, return scheme to reset.
// - Up to four shots; shots two to four use own three-pole timers.
// - Two breakers: close one selected, both together, or both in sequence.
// - Sequential: second breaker closes after first recloses and checking delay.
// - Simultaneous: both breakers close together on each shot after chosen dead time.
// - Single-pole or three-pole trip from protection initiates the scheme.
// - Enable input gates all activity; disabled by default.
// - Reset state clears shot counter and waits for a new initiation.
// - Once initiated, stay in progress until cycle succeeds or fails.
// - Lockout ignores initiations and closes nothing until reset.
// - Initiation after the last permitted shot sends the scheme to lockout.
// - Three-pole programs assert force three-pole trip.
// - First shot action depends on program and fault; later shots three-pole.
// - Reclose in progress flag latched from initiation to close, lockout or reset.
// - Force three-pole set 1.25 cycles into single-pole dead time until reset, lockout or disable.
// - Pause freezes dead timers; on release resume with second three-pole dead time.
// - Reset timer starts on close; expiry with breaker closed resets the count.
//
// Purpose: autoreclose sequencer for one or two line breakers
// Assumes: all inputs asynchronous to SYS_CLK; settings held stable
// Notes: timer settings are 16-bit counts of 10 ms ticks
`timescale 1ns/1ps
module lar_sequencer
  import lar_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = LAR_TICK_CYCLES,
  parameter int unsigned FORCE_CYCLES = LAR_FORCE_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic RECLOSE_FUNCTION_ENABLE,
  input wire logic [1:0] RECLOSE_PROGRAM_SELECT,
  input wire logic [1:0] BREAKER_SEQUENCE_SELECT,
  input wire logic [LAR_SHOT_W-1:0] MAX_SHOT_COUNT,
  input wire logic [LAR_TIME_W-1:0] BREAKER_ONE_CLOSE_PULSE_TIME,
  input wire logic [LAR_TIME_W-1:0] MANUAL_CLOSE_BLOCK_TIME,
  input wire logic [LAR_TIME_W-1:0] SINGLE_POLE_DEAD_TIME,
  input wire logic [LAR_TIME_W-1:0] THREE_POLE_DEAD_TIME_1,
  input wire logic [LAR_TIME_W-1:0] THREE_POLE_DEAD_TIME_2,
  input wire logic [LAR_TIME_W-1:0] THREE_POLE_DEAD_TIME_3,
  input wire logic [LAR_TIME_W-1:0] THREE_POLE_DEAD_TIME_4,
  input wire logic [LAR_TIME_W-1:0] DEAD_TIME_ONE_EXTENSION,
  input wire logic [LAR_TIME_W-1:0] RECLOSE_RESET_TIME,
  input wire logic [LAR_TIME_W-1:0] TRANSFER_CHECK_TIME,
  input wire logic SINGLE_POLE_INITIATE,
  input wire logic THREE_POLE_INITIATE,
  input wire logic THREE_POLE_DELAYED_INITIATE,
  input wire logic MULTIPHASE_FAULT_INPUT,
  input wire logic BREAKER_SINGLE_POLE_OPEN,
  input wire logic BREAKER_ALL_POLES_OPEN,
  input wire logic BREAKER_ONE_INHIBIT,
  input wire logic BREAKER_ONE_CLOSED,
  input wire logic BREAKER_TWO_CLOSED,
  input wire logic MANUAL_CLOSE_INPUT,
  input wire logic DEAD_TIME_ONE_EXTEND_INPUT,
  input wire logic RECLOSE_RESET_INPUT,
  input wire logic RECLOSE_PAUSE,
  output logic CLOSE_BREAKER_ONE,
  output logic CLOSE_BREAKER_TWO,
  output logic RECLOSE_IN_PROGRESS_FLAG,
  output logic FORCE_THREE_POLE_TRIP,
  output logic LOCKOUT_STATE,
  output logic RECLOSE_ENABLED,
  output logic [LAR_SHOT_W-1:0] SHOT_COUNT
);

  if (TICK_CYCLES < 2 || FORCE_CYCLES < 1 || FORCE_CYCLES >= (1 << LAR_FCNT_W)) begin : g_bad
    $error("lar_sequencer: unusable tick or force delay");
  end

  localparam int NIN = 14;
  localparam int TICK_W = $clog2(TICK_CYCLES);

  // Two-stage synchronisers for every asynchronous input bit
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] meta_ff;
  logic [NIN-1:0] sync_ff;
  assign raw_in = {RECLOSE_FUNCTION_ENABLE, SINGLE_POLE_INITIATE, THREE_POLE_INITIATE,
                   THREE_POLE_DELAYED_INITIATE, MULTIPHASE_FAULT_INPUT,
                   BREAKER_SINGLE_POLE_OPEN, BREAKER_ALL_POLES_OPEN, BREAKER_ONE_INHIBIT,
                   BREAKER_ONE_CLOSED, BREAKER_TWO_CLOSED, MANUAL_CLOSE_INPUT,
                   DEAD_TIME_ONE_EXTEND_INPUT, RECLOSE_RESET_INPUT, RECLOSE_PAUSE};

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
    end
  end

  wire en_s = sync_ff[13];
  wire init_1p = sync_ff[12];
  wire init_3p = sync_ff[11];
  wire init_3td = sync_ff[10];
  wire multi_s = sync_ff[9];
  wire pole_open_s = sync_ff[8];
  wire all_open_s = sync_ff[7];
  wire inhibit_s = sync_ff[6];
  wire bk1_closed = sync_ff[5];
  wire bk2_closed = sync_ff[4];
  wire man_s = sync_ff[3];
  wire ext_s = sync_ff[2];
  wire rst_in_s = sync_ff[1];
  wire pause_s = sync_ff[0];

  // 10 ms tick prescaler
  logic [TICK_W-1:0] pre_ff;
  logic tick_ff;
  wire pre_end = (pre_ff == TICK_W'(TICK_CYCLES - 1));
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pre_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      pre_ff <= pre_end ? '0 : pre_ff + 1'b1;
      tick_ff <= pre_end;
    end
  end

  lar_state_t state_ff, nxt_state;
  logic [LAR_TIME_W:0] tmr_ff, nxt_tmr;
  logic [LAR_TIME_W-1:0] rst_tmr_ff;
  logic [LAR_TIME_W-1:0] man_tmr_ff;
  logic [LAR_SHOT_W-1:0] shot_ff, nxt_shot;
  logic single_pole_ff, nxt_single_pole;
  logic paused_ff;
  logic [LAR_FCNT_W-1:0] fcnt_ff;
  logic force_ff;
  logic rip_ff;
  logic cls1_ff, cls2_ff;

  function automatic logic [LAR_TIME_W:0] widen(input logic [LAR_TIME_W-1:0] t);
    widen = {1'b0, t};
  endfunction

  lar_prog_t prog;
  lar_seq_t seq;
  assign prog = lar_prog_t'(RECLOSE_PROGRAM_SELECT);
  assign seq = lar_seq_t'(BREAKER_SEQUENCE_SELECT);

  // Clamp shot limit into the legal 1..4 window
  wire [LAR_SHOT_W-1:0] shot_lim = (MAX_SHOT_COUNT < LAR_SHOT_MIN) ? LAR_SHOT_MIN :
                                   (MAX_SHOT_COUNT > LAR_SHOT_MAX) ? LAR_SHOT_MAX :
                                   MAX_SHOT_COUNT;
  wire any_init = init_1p | init_3p | init_3td;
  wire man_block = (man_tmr_ff != '0);
  wire three_prog = (prog == LAR_PROG_THREE_A) || (prog == LAR_PROG_THREE_B);
  wire multi_fault = multi_s | init_3p | all_open_s;
  wire is_single = init_1p & ~multi_fault & ~init_3td;

  // First-shot decision and dead time selection
  logic first_lockout;
  logic first_single;
  logic [LAR_TIME_W:0] first_dt;
  always_comb begin
    first_lockout = 1'b0;
    first_single = 1'b0;
    first_dt = widen(THREE_POLE_DEAD_TIME_1);
    unique case (prog)
      LAR_PROG_ONE_THREE: begin
        first_single = is_single;
        if (init_3td) first_dt = widen(THREE_POLE_DEAD_TIME_2);
        else if (is_single) first_dt = widen(SINGLE_POLE_DEAD_TIME);
      end
      LAR_PROG_ONE_ONLY: begin
        first_single = 1'b1;
        first_lockout = ~is_single;
        first_dt = widen(SINGLE_POLE_DEAD_TIME);
      end
      LAR_PROG_THREE_A: begin
        first_lockout = multi_s;
      end
      LAR_PROG_THREE_B: begin
        if (init_3td) first_dt = widen(THREE_POLE_DEAD_TIME_2);
      end
    endcase
    if (ext_s && !first_single) begin
      first_dt = first_dt + widen(DEAD_TIME_ONE_EXTENSION);
    end
  end

  // Later shots: three-pole, own dead timer; program A locks out on multi-phase
  logic [LAR_TIME_W:0] later_dt;
  always_comb begin
    unique case (shot_ff)
      3'h1: later_dt = widen(THREE_POLE_DEAD_TIME_2);
      3'h2: later_dt = widen(THREE_POLE_DEAD_TIME_3);
      default: later_dt = widen(THREE_POLE_DEAD_TIME_4);
    endcase
  end
  wire later_lockout = (prog == LAR_PROG_THREE_A) && multi_s;
  wire at_limit = (shot_ff >= shot_lim);

  // Sequence-driven close targets
  wire seq_bk1 = (seq != LAR_SEQ_BKR2);
  wire seq_bk2_now = (seq == LAR_SEQ_BKR2) || (seq == LAR_SEQ_BOTH);
  wire tmr_done = (tmr_ff == '0);
  // Reset timer counts from the close command, not from the end of the pulse
  wire rst_done = (rst_tmr_ff == '0);

  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff;
    nxt_shot = shot_ff;
    nxt_single_pole = single_pole_ff;
    if (tick_ff && !tmr_done && !(state_ff == LAR_ST_DEAD && pause_s)) begin
      nxt_tmr = tmr_ff - 1'b1;
    end
    if (state_ff == LAR_ST_DEAD && paused_ff && !pause_s) begin
      nxt_tmr = widen(THREE_POLE_DEAD_TIME_2);
      nxt_single_pole = 1'b0;
    end
    unique case (state_ff)
      LAR_ST_DISABLED: begin
        if (en_s) nxt_state = LAR_ST_RESET;
      end
      LAR_ST_RESET: begin
        nxt_shot = '0;
        if (any_init && !man_block) begin
          if (first_lockout) begin
            nxt_state = LAR_ST_LOCKOUT;
          end else begin
            nxt_state = LAR_ST_DEAD;
            nxt_tmr = first_dt;
            nxt_single_pole = first_single & ~three_prog;
          end
        end
      end
      LAR_ST_DEAD: begin
        if (tmr_done && !pause_s) begin
          if (inhibit_s && seq_bk1 && seq != LAR_SEQ_BOTH) begin
            nxt_state = LAR_ST_LOCKOUT;
          end else begin
            nxt_state = LAR_ST_CLOSE;
            nxt_tmr = widen(BREAKER_ONE_CLOSE_PULSE_TIME);
            nxt_shot = shot_ff + 1'b1;
          end
        end
      end
      LAR_ST_CLOSE: begin
        if (tmr_done || (bk1_closed && seq_bk1)) begin
          if (seq == LAR_SEQ_ONE_TWO) begin
            nxt_state = LAR_ST_TRANSFER;
            nxt_tmr = widen(TRANSFER_CHECK_TIME);
          end else begin
            nxt_state = LAR_ST_RECLAIM;
          end
        end
      end
      LAR_ST_TRANSFER: begin
        if (any_init) begin
          nxt_state = LAR_ST_RECLAIM;
        end else if (tmr_done && bk1_closed) begin
          nxt_state = LAR_ST_CLOSE2;
          nxt_tmr = widen(BREAKER_ONE_CLOSE_PULSE_TIME);
        end
      end
      LAR_ST_CLOSE2: begin
        if (tmr_done || bk2_closed) nxt_state = LAR_ST_RECLAIM;
      end
      LAR_ST_RECLAIM: begin
        if (any_init) begin
          if (at_limit || later_lockout) begin
            nxt_state = LAR_ST_LOCKOUT;
          end else begin
            nxt_state = LAR_ST_DEAD;
            nxt_tmr = later_dt;
            nxt_single_pole = 1'b0;
          end
        end else if (rst_done && bk1_closed && !pole_open_s) begin
          nxt_state = LAR_ST_RESET;
          nxt_shot = '0;
        end
      end
      LAR_ST_LOCKOUT: begin
        // Initiations ignored here
      end
    endcase
    if (state_ff == LAR_ST_RESET || state_ff == LAR_ST_DISABLED) begin
      if (nxt_state == LAR_ST_DEAD) nxt_shot = '0;
    end
    if (rst_in_s && state_ff != LAR_ST_DISABLED) begin
      nxt_state = LAR_ST_RESET;
      nxt_shot = '0;
    end
    if (!en_s) begin
      nxt_state = LAR_ST_DISABLED;
      nxt_shot = '0;
    end
  end

  // Reset timer restarts on each dead-time expiry into the close state
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rst_tmr_ff <= '0;
    end else if (state_ff == LAR_ST_DEAD && nxt_state == LAR_ST_CLOSE) begin
      rst_tmr_ff <= RECLOSE_RESET_TIME;
    end else if (tick_ff && rst_tmr_ff != '0) begin
      rst_tmr_ff <= rst_tmr_ff - 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      man_tmr_ff <= '0;
    end else if (man_s) begin
      man_tmr_ff <= MANUAL_CLOSE_BLOCK_TIME;
    end else if (tick_ff && man_block) begin
      man_tmr_ff <= man_tmr_ff - 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_ff <= LAR_ST_DISABLED;
      tmr_ff <= '0;
      shot_ff <= '0;
      single_pole_ff <= 1'b0;
      paused_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      shot_ff <= nxt_shot;
      single_pole_ff <= nxt_single_pole;
      paused_ff <= pause_s && (state_ff == LAR_ST_DEAD);
    end
  end

  // Evolving-fault timer from start of single-pole dead time
  wire sp_dead = (state_ff == LAR_ST_DEAD) && single_pole_ff;
  wire idle = (state_ff == LAR_ST_RESET) || (state_ff == LAR_ST_LOCKOUT) ||
              (state_ff == LAR_ST_DISABLED);
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      fcnt_ff <= '0;
      force_ff <= 1'b0;
    end else if (idle) begin
      fcnt_ff <= '0;
      force_ff <= 1'b0;
    end else begin
      if (sp_dead && fcnt_ff != LAR_FCNT_W'(FORCE_CYCLES)) fcnt_ff <= fcnt_ff + 1'b1;
      if (sp_dead && fcnt_ff == LAR_FCNT_W'(FORCE_CYCLES - 1)) force_ff <= 1'b1;
      if (shot_ff != '0) force_ff <= 1'b1;
    end
  end

  // Outputs from flip-flops; close pulses end on breaker closure or timer
  wire nxt_rip = (state_ff == LAR_ST_DEAD) || (nxt_state == LAR_ST_DEAD);
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rip_ff <= 1'b0;
      cls1_ff <= 1'b0;
      cls2_ff <= 1'b0;
    end else begin
      rip_ff <= nxt_rip && nxt_state == LAR_ST_DEAD;
      cls1_ff <= (nxt_state == LAR_ST_CLOSE) && seq_bk1 && !bk1_closed;
      cls2_ff <= ((nxt_state == LAR_ST_CLOSE) && seq_bk2_now && !bk2_closed) ||
                 ((nxt_state == LAR_ST_CLOSE2) && !bk2_closed);
    end
  end

  assign CLOSE_BREAKER_ONE = cls1_ff;
  assign CLOSE_BREAKER_TWO = cls2_ff;
  assign RECLOSE_IN_PROGRESS_FLAG = rip_ff;
  assign FORCE_THREE_POLE_TRIP = force_ff | (three_prog & en_s);
  assign LOCKOUT_STATE = (state_ff == LAR_ST_LOCKOUT);
  assign RECLOSE_ENABLED = (state_ff != LAR_ST_DISABLED);
  assign SHOT_COUNT = shot_ff;

endmodule // lar_sequencer

//--- lar_sequencer_props.sv
// Purpose: port-level checker for the autoreclose sequencer
// Assumes: single clock domain, synchronous active-high reset
// Notes: timing bounds allow for the tick prescaler phase
`timescale 1ns/1ps
module lar_seq_props
  import lar_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = LAR_TICK_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic RECLOSE_FUNCTION_ENABLE,
  input wire logic [1:0] RECLOSE_PROGRAM_SELECT,
  input wire logic [LAR_SHOT_W-1:0] MAX_SHOT_COUNT,
  input wire logic [LAR_TIME_W-1:0] BREAKER_ONE_CLOSE_PULSE_TIME,
  input wire logic SINGLE_POLE_INITIATE,
  input wire logic THREE_POLE_INITIATE,
  input wire logic THREE_POLE_DELAYED_INITIATE,
  input wire logic CLOSE_BREAKER_ONE,
  input wire logic CLOSE_BREAKER_TWO,
  input wire logic RECLOSE_IN_PROGRESS_FLAG,
  input wire logic FORCE_THREE_POLE_TRIP,
  input wire logic LOCKOUT_STATE,
  input wire logic RECLOSE_ENABLED,
  input wire logic [LAR_SHOT_W-1:0] SHOT_COUNT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  wire init_any = SINGLE_POLE_INITIATE | THREE_POLE_INITIATE | THREE_POLE_DELAYED_INITIATE;
  wire close_any = CLOSE_BREAKER_ONE | CLOSE_BREAKER_TWO;
  int unsigned close_cnt_ff;
  always_ff @(posedge SYS_CLK) begin
    if (RESET || !CLOSE_BREAKER_ONE) close_cnt_ff <= 0;
    else close_cnt_ff <= close_cnt_ff + 1;
  end
  property p_lockout_quiet;
    LOCKOUT_STATE && $past(LOCKOUT_STATE) |-> !close_any;
  endproperty
  a_lockout_quiet: assert property (p_lockout_quiet)
    else $error("close command while locked out");
  property p_disabled_quiet;
    !RECLOSE_ENABLED && !$past(RECLOSE_ENABLED) |-> !close_any && !RECLOSE_IN_PROGRESS_FLAG;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("activity while disabled");
  property p_shot_limit;
    MAX_SHOT_COUNT >= 3'h1 && MAX_SHOT_COUNT <= 3'h4 |-> SHOT_COUNT <= MAX_SHOT_COUNT;
  endproperty
  a_shot_limit: assert property (p_shot_limit)
    else $error("shot count above limit");
  property p_shot_step;
    SHOT_COUNT != $past(SHOT_COUNT) |-> SHOT_COUNT == $past(SHOT_COUNT) + 3'h1 || SHOT_COUNT == 3'h0;
  endproperty
  a_shot_step: assert property (p_shot_step)
    else $error("shot count jumped");
  property p_shot_close;
    SHOT_COUNT == $past(SHOT_COUNT) + 3'h1 |-> ##[0:2] close_any;
  endproperty
  a_shot_close: assert property (p_shot_close)
    else $error("shot counted without close");
  property p_rip_start;
    $rose(RECLOSE_IN_PROGRESS_FLAG) |-> $past(init_any, 3) || $past(init_any, 4);
  endproperty
  a_rip_start: assert property (p_rip_start)
    else $error("in-progress without initiation");
  property p_rip_end;
    $fell(RECLOSE_IN_PROGRESS_FLAG) |-> ##[0:1] (close_any || LOCKOUT_STATE);
  endproperty
  a_rip_end: assert property (p_rip_end)
    else $error("in-progress dropped early");
  property p_close_bounded;
    close_cnt_ff <= (BREAKER_ONE_CLOSE_PULSE_TIME + 2) * TICK_CYCLES;
  endproperty
  a_close_bounded: assert property (p_close_bounded)
    else $error("close pulse too long");
  property p_force_prog;
    RECLOSE_FUNCTION_ENABLE && RECLOSE_ENABLED && $past(RECLOSE_ENABLED)
      && RECLOSE_PROGRAM_SELECT[1] |-> FORCE_THREE_POLE_TRIP;
  endproperty
  a_force_prog: assert property (p_force_prog)
    else $error("three-pole program without force");
endmodule // lar_seq_props
bind lar_sequencer lar_seq_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.SYS_CLK, .RESET,
  .RECLOSE_FUNCTION_ENABLE, .RECLOSE_PROGRAM_SELECT, .MAX_SHOT_COUNT,
  .BREAKER_ONE_CLOSE_PULSE_TIME, .SINGLE_POLE_INITIATE, .THREE_POLE_INITIATE,
  .THREE_POLE_DELAYED_INITIATE, .CLOSE_BREAKER_ONE, .CLOSE_BREAKER_TWO,
  .RECLOSE_IN_PROGRESS_FLAG, .FORCE_THREE_POLE_TRIP, .LOCKOUT_STATE, .RECLOSE_ENABLED,
  .SHOT_COUNT);

//--- lar_breaker_model.sv
// Purpose: behavioural circuit breaker on the far side of the sequencer
// Assumes: close command is a level, trip opens all poles at once
// Notes: stuck holds the breaker open to exercise the close timer
`timescale 1ns/1ps
module lar_breaker_model #(
  parameter int CLOSE_DLY = 3
) (
  input wire logic clk,
  input wire logic close_cmd,
  input wire logic trip,
  input wire logic stuck,
  output logic closed
);
  logic closed_ff = 1'b1;
  int cnt_ff = 0;
  assign closed = closed_ff;
  always_ff @(posedge clk) begin
    if (trip) begin
      closed_ff <= 1'b0;
      cnt_ff <= 0;
    end else if (close_cmd && !stuck) begin
      cnt_ff <= cnt_ff + 1;
      if (cnt_ff >= CLOSE_DLY) closed_ff <= 1'b1;
    end else cnt_ff <= 0;
  end
endmodule // lar_breaker_model

//--- line_autoreclose_sequencer_tb.sv
// Purpose: self-checking bench for the autoreclose sequencer
// Assumes: 10-cycle tick, timer settings of a few ticks
// Notes: dead times spaced two ticks apart so windows never overlap
`timescale 1ns/1ps
module line_autoreclose_sequencer_tb;
  import lar_pkg::*;
  localparam int TK = 10;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, spo = 1'b0;
  logic [1:0] prog = 2'h0, seq = 2'h0;
  logic [2:0] max_shot = 3'h2, shots;
  logic sp = 1'b0, tp = 1'b0, dly = 1'b0, mp = 1'b0, trip = 1'b0, inh = 1'b0;
  logic man = 1'b0, ext = 1'b0, rri = 1'b0, pause = 1'b0, stuck = 1'b0;
  logic [15:0] t_sp = 16'h0002, t_d1 = 16'h0004, t_d2 = 16'h0006, t_d3 = 16'h0008;
  logic [15:0] t_d4 = 16'h000a, t_ext = 16'h0004, t_cls = 16'h0003, t_man = 16'h0014;
  logic [15:0] t_rst = 16'h0005, t_xfr = 16'h0002;
  logic cb1, cb2, rip, f3p, lo, ena, b1c, b2c, sc0;
  int n_mismatch = 0, checked = 0;
  assign sc0 = (shots == 3'h0);
  localparam int W_CB1 = 0, W_CB2 = 1, W_LO = 2, W_SC0 = 3;
  logic [3:0] watch;
  assign watch = {sc0, lo, cb2, cb1};
  initial begin
    forever #2 clk = ~clk;
  end
  lar_sequencer #(.TICK_CYCLES(TK), .FORCE_CYCLES(5)) dut (
    .SYS_CLK(clk), .RESET(rst), .RECLOSE_FUNCTION_ENABLE(en), .RECLOSE_PROGRAM_SELECT(prog),
    .BREAKER_SEQUENCE_SELECT(seq), .MAX_SHOT_COUNT(max_shot),
    .BREAKER_ONE_CLOSE_PULSE_TIME(t_cls), .MANUAL_CLOSE_BLOCK_TIME(t_man),
    .SINGLE_POLE_DEAD_TIME(t_sp), .THREE_POLE_DEAD_TIME_1(t_d1), .THREE_POLE_DEAD_TIME_2(t_d2),
    .THREE_POLE_DEAD_TIME_3(t_d3), .THREE_POLE_DEAD_TIME_4(t_d4),
    .DEAD_TIME_ONE_EXTENSION(t_ext), .RECLOSE_RESET_TIME(t_rst), .TRANSFER_CHECK_TIME(t_xfr),
    .SINGLE_POLE_INITIATE(sp), .THREE_POLE_INITIATE(tp), .THREE_POLE_DELAYED_INITIATE(dly),
    .MULTIPHASE_FAULT_INPUT(mp), .BREAKER_SINGLE_POLE_OPEN(spo), .BREAKER_ALL_POLES_OPEN(!b1c),
    .BREAKER_ONE_INHIBIT(inh), .BREAKER_ONE_CLOSED(b1c), .BREAKER_TWO_CLOSED(b2c),
    .MANUAL_CLOSE_INPUT(man), .DEAD_TIME_ONE_EXTEND_INPUT(ext), .RECLOSE_RESET_INPUT(rri),
    .RECLOSE_PAUSE(pause), .CLOSE_BREAKER_ONE(cb1), .CLOSE_BREAKER_TWO(cb2),
    .RECLOSE_IN_PROGRESS_FLAG(rip), .FORCE_THREE_POLE_TRIP(f3p), .LOCKOUT_STATE(lo),
    .RECLOSE_ENABLED(ena), .SHOT_COUNT(shots));
  lar_breaker_model u_bkr1 (.clk(clk), .close_cmd(cb1), .trip(trip), .stuck(stuck),
    .closed(b1c));
  lar_breaker_model u_bkr2 (.clk(clk), .close_cmd(cb2), .trip(trip), .stuck(1'b0),
    .closed(b2c));
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic fail(input logic [31:0] g, input logic [31:0] e);
    n_mismatch++;
    $display("Error at %0t ns: got %h expected %h", $time, g, e);
  endtask
  task automatic chk1(input logic g, input logic e);
    checked++;
    if (g !== e) fail(32'(g), 32'(e));
  endtask
  task automatic chk3(input logic [2:0] g, input logic [2:0] e);
    checked++;
    if (g !== e) fail(32'(g), 32'(e));
  endtask
  task automatic chkn(input int g, input int lo_b, input int hi_b);
    checked++;
    if (g < lo_b || g > hi_b) fail(g, lo_b);
  endtask
  task automatic wait_for(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (watch[w] !== v) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        fail(n, lim);
        close_out();
      end
    end
  endtask
  task automatic start(input logic e, input logic [1:0] p, input logic [1:0] s);
    rst = 1'b1;
    en = e;
    prog = p;
    seq = s;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask
  // Kind is {multiphase, delayed, three-pole, single-pole}; d of 0 expects no close
  task automatic shot(input logic [3:0] kind, input int d);
    int n;
    n = 0;
    // Let an edge pass so back-to-back shots never drive a pin twice at once
    @(posedge clk);
    #1;
    {mp, dly, tp, sp} = kind;
    trip = 1'b1;
    if (d == 0) begin
      repeat (150) begin
        @(posedge clk);
        #1;
        n += int'(cb1 | cb2);
      end
      chkn(n, 0, 0);
    end else begin
      wait_for(W_CB1, 1'b1, d * TK + 20, n);
      chkn(n, (d - 1) * TK, d * TK + 8);
    end
    {mp, dly, tp, sp} = 4'h0;
    trip = 1'b0;
  endtask
  task automatic settle();
    int n;
    wait_for(W_CB1, 1'b0, 60, n);
    wait_for(W_SC0, 1'b1, (5 + 2) * TK + 8, n);
  endtask
  task automatic t_basic();
    int n;
    start(1'b1, 2'h0, 2'h0);
    shot(4'h1, 2);
    chk3(shots, 3'h1);
    chk1(f3p, 1'b1);
    settle();
    shot(4'h2, 4);
    settle();
    ext = 1'b1;
    shot(4'h2, 8);
    ext = 1'b0;
    settle();
    shot(4'h4, 6);
    wait_for(W_CB1, 1'b0, 60, n);
    shot(4'h2, 6);
    chk3(shots, 3'h2);
    wait_for(W_CB1, 1'b0, 60, n);
    shot(4'h2, 0);
    chk1(lo, 1'b1);
    shot(4'h2, 0);
    rri = 1'b1;
    wait_for(W_LO, 1'b0, 20, n);
    rri = 1'b0;
    $display("basic cycle test done");
  endtask
  task automatic t_block();
    int n;
    start(1'b0, 2'h0, 2'h0);
    shot(4'h2, 0);
    chk1(rip, 1'b0);
    chk1(ena, 1'b0);
    start(1'b1, 2'h0, 2'h0);
    man = 1'b1;
    repeat (4) @(posedge clk);
    #1 man = 1'b0;
    shot(4'h2, 0);
    start(1'b1, 2'h0, 2'h0);
    pause = 1'b1;
    shot(4'h2, 0);
    pause = 1'b0;
    // Release restarts the wait on the second three-pole dead time
    wait_for(W_CB1, 1'b1, 6 * TK + 20, n);
    chkn(n, 5 * TK, 6 * TK + 8);
    start(1'b1, 2'h0, 2'h0);
    inh = 1'b1;
    shot(4'h2, 0);
    chk1(lo, 1'b1);
    inh = 1'b0;
    $display("blocking test done");
  endtask
  task automatic t_prog();
    int n;
    start(1'b1, 2'h1, 2'h0);
    shot(4'ha, 0);
    chk1(lo, 1'b1);
    start(1'b1, 2'h2, 2'h0);
    chk1(f3p, 1'b1);
    shot(4'ha, 0);
    chk1(lo, 1'b1);
    start(1'b1, 2'h3, 2'h0);
    chk1(f3p, 1'b1);
    stuck = 1'b1;
    shot(4'ha, 4);
    wait_for(W_CB1, 1'b0, (3 + 1) * TK + 8, n);
    stuck = 1'b0;
    $display("program test done");
  endtask
  task automatic t_seq();
    int n;
    start(1'b1, 2'h0, 2'h3);
    shot(4'h2, 4);
    chk1(cb2, 1'b0);
    wait_for(W_CB2, 1'b1, (2 + 2) * TK + 30, n);
    start(1'b1, 2'h0, 2'h2);
    shot(4'h2, 4);
    chk1(cb2, 1'b1);
    $display("breaker sequence test done");
  endtask
  initial begin
    t_basic();
    t_block();
    t_prog();
    t_seq();
    close_out();
  end
endmodule // line_autoreclose_sequencer_tb
